/* File: src/itml_timer.sv */
// One 16-bit interval timer channel: gate handling, loading, counting and output per mode
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - One-shot: high, low after trigger until zero
// - One-shot: each trigger reloads, N-pulse low
// - One-shot: new count waits for next trigger
// - Rate: low one pulse at 1, reload
// - Rate: gate low stops, forces high; edge reloads
// - Rate: load next pulse after count write
// - Rate: new count at period end or trigger
// - Square: high half, low half, period N
// - Square: gate low stops, forces high; edge reloads
// - Square: new count at half end or trigger
// - Square even: step two, toggle at 2
// - Square odd: load N-1, low one late
// - Soft strobe: write starts, low at count 1, N ticks later
// - Soft strobe: second byte arms the load
// - Gate strobe: edge loads, strobe at count 1, N ticks later
// - Gate strobe: new count waits for trigger
// - Gate sampled on rise, edges latched
// - Load and decrement on tick falling edge
// - Zero count means maximum count
// - Modes 0,1,4,5 wrap; 2,3 reload
// - Mode 0: low until zero, then high
// - Gate fixed high or port bit, reset low
// - Control word write resets logic at once
module itml_timer
   import itml_pkg::*;
#(
   parameter int TIMER_INDEX = 2
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   // Timer tick pin
   input  wire logic        timer_tick_input_in,
   // Software writes
   input  wire logic        cw_wr_in,
   input  wire itml_cw_t    cw_in,
   input  wire itml_byte_t  cnt_byte_in,
   // Internal control port gate bit
   input  wire logic        gate_port_wr_in,
   input  wire logic        gate_port_bit_in,
   // Channel state
   output logic             timer_signal_out,
   output logic [15:0]      count_value_out,
   output logic             count_loaded_out
);

   function automatic logic [15:0] itml_dec(input logic [15:0] v, input logic bcd, input logic [1:0] k);
      logic [15:0] r;
      logic [4:0]  d;
      logic [1:0]  b;
      r = v;
      b = k;
      for (int i = 0; i < 4; i++) begin
         d = {1'b0, v[4*i +: 4]} - {3'b000, b};
         r[4*i +: 4] = d[4] ? 4'(d + 5'h0A) : d[3:0];
         b = {1'b0, d[4]};
      end
      return bcd ? r : 16'(v - {14'h0000, k});
   endfunction : itml_dec

   // Registers
   logic        tick_s1_r;
   logic        tick_s2_r;
   logic        tick_d_r;
   logic        gate_r;
   logic        gate_prev_r;
   logic        trig_ff_r;
   logic        trig_s_r;
   logic        gate_s_r;
   itml_cw_t    cw_r;
   logic [15:0] cr_r;
   logic [15:0] ce_r;
   logic        out_r;
   logic        loaded_r;
   logic        cnt_ok_r;
   logic        pend_r;
   logic        armed_r;
   logic        extra_r;
   logic        byte_hi_r;

   // Next-state values applied on a tick falling edge
   logic [15:0] ce_nxt;
   logic        out_nxt;
   logic        loaded_nxt;
   logic        pend_nxt;
   logic        armed_nxt;
   logic        extra_nxt;

   // Decode
   wire         tick_rise = tick_s2_r & ~tick_d_r;
   wire         tick_fall = ~tick_s2_r & tick_d_r;
   wire         gate      = (TIMER_INDEX < ITML_FREE_GATES) ? 1'b1 : gate_r;
   wire         gate_rise = gate & ~gate_prev_r;
   wire         both_fmt  = (cw_r.rw == ITML_RW_BOTH);
   wire         wr        = cnt_byte_in.wr;
   wire         wr_done   = wr & (~both_fmt | byte_hi_r);
   wire         wr_first  = wr & both_fmt & ~byte_hi_r;
   wire [15:0]  cr_wr     = (cw_r.rw == ITML_RW_MSB) ? {cnt_byte_in.data, 8'h00} :
                            (cw_r.rw == ITML_RW_LSB) ? {8'h00, cnt_byte_in.data} :
                            byte_hi_r ? {cnt_byte_in.data, cr_r[7:0]} : {cr_r[15:8], cnt_byte_in.data};
   wire [15:0]  dec1      = itml_dec(ce_r, cw_r.bcd, 2'h1);
   wire [15:0]  dec2      = itml_dec(ce_r, cw_r.bcd, 2'h2);
   wire [15:0]  sq_reload = {cr_r[15:1], 1'b0};
   wire         is_m0     = (cw_r.mode == ITML_MODE0);
   wire         periodic  = (cw_r.mode == ITML_MODE2) | (cw_r.mode == ITML_MODE3);
   wire         force_hi  = periodic & ~gate;
   wire         m0_hold   = is_m0 & byte_hi_r;

   always_comb begin
      ce_nxt     = ce_r;
      out_nxt    = out_r;
      loaded_nxt = loaded_r;
      pend_nxt   = pend_r;
      armed_nxt  = armed_r;
      extra_nxt  = extra_r;
      case (cw_r.mode)
         ITML_MODE0: begin
            if (pend_r) begin
               ce_nxt     = cr_r;
               pend_nxt   = 1'b0;
               loaded_nxt = 1'b1;
            end else if (loaded_r & gate_s_r & ~m0_hold) begin
               ce_nxt  = dec1;
               out_nxt = out_r | (dec1 == ITML_ZERO);
            end
         end
         ITML_MODE1: begin
            if (trig_s_r & cnt_ok_r) begin
               ce_nxt     = cr_r;
               out_nxt    = 1'b0;
               loaded_nxt = 1'b1;
            end else if (loaded_r) begin
               ce_nxt  = dec1;
               out_nxt = out_r | (dec1 == ITML_ZERO);
            end
         end
         ITML_MODE2: begin
            if ((trig_s_r | ~loaded_r) & cnt_ok_r) begin
               ce_nxt     = cr_r;
               loaded_nxt = 1'b1;
               out_nxt    = 1'b1;
            end else if (loaded_r & gate_s_r) begin
               if (ce_r == ITML_ONE) begin
                  ce_nxt  = cr_r;
                  out_nxt = 1'b1;
               end else begin
                  ce_nxt  = dec1;
                  out_nxt = (dec1 != ITML_ONE);
               end
            end
         end
         ITML_MODE3: begin
            if ((trig_s_r | ~loaded_r) & cnt_ok_r) begin
               ce_nxt     = sq_reload;
               loaded_nxt = 1'b1;
               out_nxt    = 1'b1;
               extra_nxt  = 1'b0;
            end else if (loaded_r & gate_s_r) begin
               if (extra_r) begin
                  out_nxt   = 1'b0;
                  ce_nxt    = sq_reload;
                  extra_nxt = 1'b0;
               end else if (ce_r == ITML_TWO) begin
                  if (out_r & cr_r[0]) begin
                     extra_nxt = 1'b1;
                     ce_nxt    = dec2;
                  end else begin
                     out_nxt = ~out_r;
                     ce_nxt  = sq_reload;
                  end
               end else begin
                  ce_nxt = dec2;
               end
            end
         end
         ITML_MODE4: begin
            if (pend_r) begin
               ce_nxt     = cr_r;
               pend_nxt   = 1'b0;
               armed_nxt  = 1'b1;
               loaded_nxt = 1'b1;
               out_nxt    = 1'b1;
            end else if (loaded_r & gate_s_r) begin
               ce_nxt    = dec1;
               out_nxt   = ~(armed_r & (dec1 == ITML_ONE));
               armed_nxt = armed_r & (dec1 != ITML_ONE);
            end
         end
         ITML_MODE5: begin
            if (trig_s_r & cnt_ok_r) begin
               ce_nxt     = cr_r;
               armed_nxt  = 1'b1;
               loaded_nxt = 1'b1;
               out_nxt    = 1'b1;
            end else if (loaded_r) begin
               ce_nxt    = dec1;
               out_nxt   = ~(armed_r & (dec1 == ITML_ONE));
               armed_nxt = armed_r & (dec1 != ITML_ONE);
            end
         end
         default: ce_nxt = ce_r;
      endcase
   end

   // Tick pin synchroniser; only the second stage is decoded
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         tick_s1_r <= 1'b0;
         tick_s2_r <= 1'b0;
         tick_d_r  <= 1'b0;
      end else begin
         tick_s1_r <= timer_tick_input_in;
         tick_s2_r <= tick_s1_r;
         tick_d_r  <= tick_s2_r;
      end
   end

   // Gate port bit, edge latch and rising-edge sampling
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         gate_r      <= ITML_GATE_RST;
         // Start at the gate's reset level so a tied-high gate gives no false trigger
         gate_prev_r <= (TIMER_INDEX < ITML_FREE_GATES);
         trig_ff_r   <= 1'b0;
         trig_s_r    <= 1'b0;
         gate_s_r    <= 1'b0;
      end else begin
         if (gate_port_wr_in) begin
            gate_r <= gate_port_bit_in;
         end
         gate_prev_r <= gate;
         // A new edge wins over the clear so no trigger is lost
         trig_ff_r   <= gate_rise | (trig_ff_r & ~tick_rise);
         if (tick_rise) begin
            trig_s_r <= trig_ff_r;
            gate_s_r <= gate;
         end
      end
   end

   // Software side: control word and count holding register
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         cw_r      <= ITML_CW_RST;
         cr_r      <= ITML_CR_RST;
         byte_hi_r <= 1'b0;
         cnt_ok_r  <= 1'b0;
      end else if (cw_wr_in) begin
         cw_r      <= cw_in;
         cr_r      <= ITML_CR_RST;
         byte_hi_r <= 1'b0;
         cnt_ok_r  <= 1'b0;
      end else if (wr) begin
         cr_r      <= cr_wr;
         byte_hi_r <= wr_first;
         cnt_ok_r  <= cnt_ok_r | wr_done;
      end
   end

   // Counting element moved only on the tick falling edge; output also on control word, mode 0 count write and gate-low force
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         ce_r     <= ITML_CE_RST;
         out_r    <= ITML_OUT_RST;
         loaded_r <= 1'b0;
         pend_r   <= 1'b0;
         armed_r  <= 1'b0;
         extra_r  <= 1'b0;
      end else if (cw_wr_in) begin
         out_r    <= (cw_in.mode != ITML_MODE0);
         loaded_r <= 1'b0;
         pend_r   <= 1'b0;
         armed_r  <= 1'b0;
         extra_r  <= 1'b0;
      end else begin
         if (tick_fall) begin
            ce_r     <= ce_nxt;
            loaded_r <= loaded_nxt;
            armed_r  <= armed_nxt;
            extra_r  <= extra_nxt;
         end
         // Completed write wins over a load in the same cycle
         pend_r <= wr_done | (tick_fall ? pend_nxt : pend_r);
         // Mode 0 drops the output as soon as any count byte lands
         if (is_m0 & wr) begin
            out_r <= 1'b0;
         end else if (force_hi) begin
            out_r <= 1'b1;
         end else if (tick_fall) begin
            out_r <= out_nxt;
         end
      end
   end

   assign timer_signal_out = out_r;
   assign count_value_out  = ce_r;
   assign count_loaded_out = loaded_r;

   // Checks
   sequence s_m1_trig;
      tick_fall && cw_r.mode == ITML_MODE1 && trig_s_r && cnt_ok_r && !cw_wr_in;
   endsequence
   sequence s_low_held;
      !timer_signal_out && count_value_out == $past(cr_r);
   endsequence
   property p_oneshot_start;
      @(posedge clk_in) disable iff (!nrst_in) s_m1_trig |=> s_low_held;
   endproperty
   a_oneshot_start: assert property (p_oneshot_start) else $error("one-shot did not load and go low");
   // Gate-low force and a control word may legally end the strobe early
   property p_rate_strobe;
      @(posedge clk_in) disable iff (!nrst_in)
         (tick_fall && cw_r.mode == ITML_MODE2 && loaded_r && gate_s_r && gate && !trig_s_r
          && ce_r == ITML_TWO && !cw_wr_in)
         |=> !timer_signal_out ##1 (!timer_signal_out || $past(cw_wr_in) || $past(force_hi));
   endproperty
   a_rate_strobe: assert property (p_rate_strobe) else $error("rate strobe missing at count one");
   property p_gate_force;
      @(posedge clk_in) disable iff (!nrst_in)
         (periodic && !gate && !cw_wr_in) |=> timer_signal_out;
   endproperty
   a_gate_force: assert property (p_gate_force) else $error("gate low did not force output high");
   property p_sq_toggle;
      @(posedge clk_in) disable iff (!nrst_in)
         (tick_fall && cw_r.mode == ITML_MODE3 && loaded_r && gate_s_r && gate && !trig_s_r && !extra_r
          && ce_r == ITML_TWO && !(out_r && cr_r[0]) && !cw_wr_in && !wr)
         |=> timer_signal_out != $past(timer_signal_out) && count_value_out == $past(sq_reload);
   endproperty
   a_sq_toggle: assert property (p_sq_toggle) else $error("square wave did not toggle at two");
   property p_soft_load;
      @(posedge clk_in) disable iff (!nrst_in)
         (tick_fall && cw_r.mode == ITML_MODE4 && pend_r && !cw_wr_in) |=> count_value_out == $past(cr_r);
   endproperty
   a_soft_load: assert property (p_soft_load) else $error("written count not loaded undecremented");
   property p_gate_strobe_load;
      @(posedge clk_in) disable iff (!nrst_in)
         (tick_fall && cw_r.mode == ITML_MODE5 && trig_s_r && cnt_ok_r && !cw_wr_in)
         |=> count_value_out == $past(cr_r) && timer_signal_out;
   endproperty
   a_gate_strobe_load: assert property (p_gate_strobe_load) else $error("trigger did not reload count");
   property p_trig_latch;
      @(posedge clk_in) disable iff (!nrst_in) (gate_rise && !tick_rise) |=> trig_ff_r;
   endproperty
   a_trig_latch: assert property (p_trig_latch) else $error("gate edge not latched");
   property p_fall_only;
      @(posedge clk_in) disable iff (!nrst_in) !tick_fall |=> $stable(count_value_out);
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("count moved off the falling tick edge");
   property p_wrap;
      @(posedge clk_in) disable iff (!nrst_in)
         (tick_fall && is_m0 && loaded_r && gate_s_r && !pend_r && !m0_hold && !cw_r.bcd
          && ce_r == ITML_ZERO && !cw_wr_in) |=> count_value_out == ITML_BIN_TOP;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap from zero");
   property p_cw_reset;
      @(posedge clk_in) disable iff (!nrst_in)
         cw_wr_in |=> timer_signal_out == ($past(cw_in.mode) != ITML_MODE0) && !count_loaded_out;
   endproperty
   a_cw_reset: assert property (p_cw_reset) else $error("control word did not reset channel");
   property p_gate_reset;
      @(posedge clk_in) disable iff (!nrst_in) $rose(nrst_in) |-> !gate_r;
   endproperty
   a_gate_reset: assert property (p_gate_reset) else $error("gate not low after reset");

endmodule : itml_timer

`default_nettype wire

/* File: src/itml_pkg.sv */
// Constants and carrier types for the interval timer mode logic
package itml_pkg;
   localparam logic [2:0]  ITML_MODE0   = 3'h0;
   localparam logic [2:0]  ITML_MODE1   = 3'h1;
   localparam logic [2:0]  ITML_MODE2   = 3'h2;
   localparam logic [2:0]  ITML_MODE3   = 3'h3;
   localparam logic [2:0]  ITML_MODE4   = 3'h4;
   localparam logic [2:0]  ITML_MODE5   = 3'h5;
   localparam logic [1:0]  ITML_RW_LSB  = 2'h1;
   localparam logic [1:0]  ITML_RW_MSB  = 2'h2;
   localparam logic [1:0]  ITML_RW_BOTH = 2'h3;
   localparam logic [15:0] ITML_CR_RST  = 16'h0000;
   localparam logic [15:0] ITML_CE_RST  = 16'h0000;
   localparam logic [15:0] ITML_BIN_TOP = 16'hFFFF;
   localparam logic [15:0] ITML_BCD_TOP = 16'h9999;
   localparam logic [15:0] ITML_ONE     = 16'h0001;
   localparam logic [15:0] ITML_TWO     = 16'h0002;
   localparam logic [15:0] ITML_ZERO    = 16'h0000;
   localparam logic        ITML_GATE_RST = 1'b0;
   localparam logic        ITML_OUT_RST  = 1'b1;
   localparam int          ITML_FREE_GATES = 2;

   // Control word fields for this channel
   typedef struct packed {
      logic [1:0] rw;
      logic [2:0] mode;
      logic       bcd;
   } itml_cw_t;

   // One byte write to the count holding register
   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } itml_byte_t;

   localparam itml_cw_t ITML_CW_RST = '{rw: ITML_RW_LSB, mode: ITML_MODE0, bcd: 1'b0};
endpackage : itml_pkg

/* File: dv/itml_timer_bench.sv */
// Self-checking bench for the interval timer mode logic
`timescale 1ns/100ps
`default_nettype none
module itml_timer_bench
   import itml_pkg::*;
;
   logic        clk;
   logic        nrst;
   logic        tick;
   logic        cw_wr;
   itml_cw_t    cw;
   itml_byte_t  cbyte;
   logic        gwr;
   logic        gbit;
   logic        tout;
   logic [15:0] cnt;
   logic        loaded;
   int          fail_count;
   int          checks;
   int          lows;

   initial clk = 1'b0;
   always #20 clk = ~clk;

   itml_timer #(.TIMER_INDEX(2)) itml_timer_inst (
      .clk_in              (clk),
      .nrst_in             (nrst),
      .timer_tick_input_in (tick),
      .cw_wr_in            (cw_wr),
      .cw_in               (cw),
      .cnt_byte_in         (cbyte),
      .gate_port_wr_in     (gwr),
      .gate_port_bit_in    (gbit),
      .timer_signal_out    (tout),
      .count_value_out     (cnt),
      .count_loaded_out    (loaded)
   );

   task automatic final_report;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr_cw(input logic [2:0] m, input logic [1:0] rw, input logic bcd);
      @(posedge clk) #1;
      cw_wr = 1'b1;
      cw    = '{rw: rw, mode: m, bcd: bcd};
      @(posedge clk) #1;
      cw_wr = 1'b0;
   endtask : wr_cw

   task automatic wr_byte(input logic [7:0] d);
      @(posedge clk) #1;
      cbyte = '{wr: 1'b1, data: d};
      @(posedge clk) #1;
      cbyte.wr = 1'b0;
   endtask : wr_byte

   // Gate level lands one cycle after the port write
   task automatic set_gate(input logic v);
      @(posedge clk) #1;
      gwr  = 1'b1;
      gbit = v;
      @(posedge clk) #1;
      gwr = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : set_gate

   // Tick pin held high 4 cycles, then low 5 before return; outputs settle 3 cycles after the fall
   task automatic pulse;
      @(posedge clk) #1;
      tick = 1'b1;
      repeat (4) @(posedge clk);
      #1 tick = 1'b0;
      repeat (5) @(posedge clk);
      #1;
   endtask : pulse

   task automatic step(input logic [15:0] c, input logic o);
      pulse();
      chk("count", cnt, c);
      chk("out", {15'h0000, tout}, {15'h0000, o});
   endtask : step

   task automatic count_lows(input int n);
      lows = 0;
      for (int i = 0; i < n; i++) begin
         pulse();
         if (tout === 1'b0) begin
            lows++;
         end
      end
   endtask : count_lows

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      final_report();
   end

   initial begin
      nrst       = 1'b0;
      tick       = 1'b0;
      cw_wr      = 1'b0;
      cw         = ITML_CW_RST;
      cbyte      = '0;
      gwr        = 1'b0;
      gbit       = 1'b0;
      fail_count = 0;
      checks     = 0;
      repeat (4) @(posedge clk);
      #1 nrst = 1'b1;
      chk("rst_out", {15'h0000, tout}, 16'h0001);
      chk("rst_cnt", cnt, 16'h0000);
      chk("rst_loaded", {15'h0000, loaded}, 16'h0000);
      // Mode 0: low from control word until terminal count, then wraps
      set_gate(1'b1);
      wr_cw(ITML_MODE0, ITML_RW_LSB, 1'b0);
      chk("m0_cw_out", {15'h0000, tout}, 16'h0000);
      wr_byte(8'h02);
      step(16'h0002, 1'b0);
      step(16'h0001, 1'b0);
      step(16'h0000, 1'b1);
      step(16'hFFFF, 1'b1);
      // Mode 2: divide by three, then a new count at period end
      wr_cw(ITML_MODE2, ITML_RW_LSB, 1'b0);
      chk("m2_cw_out", {15'h0000, tout}, 16'h0001);
      wr_byte(8'h03);
      step(16'h0003, 1'b1);
      step(16'h0002, 1'b1);
      step(16'h0001, 1'b0);
      step(16'h0003, 1'b1);
      step(16'h0002, 1'b1);
      wr_byte(8'h04);
      step(16'h0001, 1'b0);
      step(16'h0004, 1'b1);
      step(16'h0003, 1'b1);
      step(16'h0002, 1'b1);
      step(16'h0001, 1'b0);
      // Gate falls during the low pulse: forced high, counting frozen
      set_gate(1'b0);
      chk("m2_gate_out", {15'h0000, tout}, 16'h0001);
      pulse();
      chk("m2_hold_cnt", cnt, 16'h0001);
      set_gate(1'b1);
      step(16'h0004, 1'b1);
      step(16'h0003, 1'b1);
      step(16'h0002, 1'b1);
      step(16'h0001, 1'b0);
      // Control word mid-count resets the channel at once
      wr_cw(ITML_MODE2, ITML_RW_LSB, 1'b0);
      chk("cw_out", {15'h0000, tout}, 16'h0001);
      chk("cw_loaded", {15'h0000, loaded}, 16'h0000);
      // Mode 3 even and odd counts: duty cycle over whole periods
      wr_cw(ITML_MODE3, ITML_RW_LSB, 1'b0);
      wr_byte(8'h04);
      step(16'h0004, 1'b1);
      count_lows(8);
      chk("m3_even_lows", 16'(lows), 16'h0004);
      wr_cw(ITML_MODE3, ITML_RW_LSB, 1'b0);
      wr_byte(8'h05);
      step(16'h0004, 1'b1);
      count_lows(10);
      chk("m3_odd_lows", 16'(lows), 16'h0004);
      for (int i = 0; i < 6 && tout !== 1'b0; i++) begin
         pulse();
      end
      set_gate(1'b0);
      chk("m3_gate_out", {15'h0000, tout}, 16'h0001);
      set_gate(1'b1);
      step(16'h0004, 1'b1);
      // New count mid half-cycle waits for the half-cycle end
      wr_byte(8'h06);
      step(16'h0002, 1'b1);
      step(16'h0006, 1'b0);
      // Mode 1: armed by count, fired by a gate edge, retriggered
      wr_cw(ITML_MODE1, ITML_RW_LSB, 1'b0);
      chk("m1_cw_out", {15'h0000, tout}, 16'h0001);
      wr_byte(8'h03);
      pulse();
      chk("m1_idle_out", {15'h0000, tout}, 16'h0001);
      chk("m1_idle_loaded", {15'h0000, loaded}, 16'h0000);
      set_gate(1'b0);
      set_gate(1'b1);
      step(16'h0003, 1'b0);
      step(16'h0002, 1'b0);
      wr_byte(8'h05);
      step(16'h0001, 1'b0);
      step(16'h0000, 1'b1);
      step(16'hFFFF, 1'b1);
      set_gate(1'b0);
      set_gate(1'b1);
      step(16'h0005, 1'b0);
      // Mode 4: two-byte count, single strobe, no repeat after wrap
      wr_cw(ITML_MODE4, ITML_RW_BOTH, 1'b0);
      wr_byte(8'h03);
      wr_byte(8'h00);
      step(16'h0003, 1'b1);
      count_lows(6);
      chk("m4_lows", 16'(lows), 16'h0001);
      // First byte alone leaves the count running down past the wrap
      wr_byte(8'h07);
      pulse();
      chk("m4_half_cnt", cnt, 16'hFFFC);
      wr_byte(8'h00);
      step(16'h0007, 1'b1);
      // Zero count is the largest count in both number systems
      wr_cw(ITML_MODE4, ITML_RW_LSB, 1'b0);
      wr_byte(8'h00);
      step(16'h0000, 1'b1);
      step(16'hFFFF, 1'b1);
      wr_cw(ITML_MODE4, ITML_RW_LSB, 1'b1);
      wr_byte(8'h00);
      step(16'h0000, 1'b1);
      step(16'h9999, 1'b1);
      // Mode 5: short gate blip between tick rises must still fire
      wr_cw(ITML_MODE5, ITML_RW_LSB, 1'b0);
      wr_byte(8'h02);
      pulse();
      chk("m5_idle_loaded", {15'h0000, loaded}, 16'h0000);
      set_gate(1'b0);
      set_gate(1'b1);
      set_gate(1'b0);
      step(16'h0002, 1'b1);
      wr_byte(8'h06);
      pulse();
      chk("m5_run_cnt", cnt, 16'h0001);
      set_gate(1'b1);
      pulse();
      chk("m5_retrig_cnt", cnt, 16'h0006);
      final_report();
   end
endmodule : itml_timer_bench
`default_nettype wire
